// ==== src/switch_port_mode_control.sv ====
// How it works
// [R01] Set change-started when a partition state change begins, change-done at end.
// [R02] A partition is disabled, in fundamental reset or active, per its state field.
// [R03] Software waits for a started change to finish before further changes.
// [R04] Change-done rises only after resulting port mode changes have settled.
// [R05] Software must not change partition state during a port mode change.
// [R06] Software must not change partition state while ports are being added.
// [R07] Transitions to active do not complete while partition reset input is low.
// [R08] Ports are disabled, unattached, upstream or downstream; only last two attach.
// [R09] Effective mode is the mode field, but disabled partition forces disabled.
// [R10] A disabled port sends no messages and drives all its outputs negated.
// [R11] A disabled port ignores its inputs, partition reset and partition state.
// [R12] Disabling sends LTSSM to Detect, powers lanes off and gates the clock.
// [R13] Disabled port keeps registers, global access only, refuses own config requests.
// [R14] Disabled port uses downstream register layout.
// [R15] Merge strap sampled only at switch reset; later levels have no effect.
// [R16] Unattached port trains as upstream into L0 and ignores power settings.
// [R17] Unattached port keeps lanes and link outputs live, negates hot-plug outputs.
// [R18] Unattached port runs only config and flow control logic, sends no messages.
// [R19] Unattached port answers config requests with retry unless global access.
// [R20] Unattached port serves global-access address and data registers normally.
// [R21] Unattached port flags other requests unsupported, drops completions with credit.
// [R22] Unattached port uses downstream layout except link registers act upstream.
// [R23] Unattached port ignores hot reset, link down and slot power messages.
// [R24] Unattached port skips auto speed change unless the speed control bit is set.
// [R25] Mode and partition state codes are chosen in the package enums.
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module switch_port_mode_control
   import spmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic partition_reset_in_n,
   input wire logic port_merge_strap_n,
   input wire spmc_hp_in_t hotplugIn,
   input wire logic linkUpIn,
   input wire logic linkActiveIn,
   input wire logic linkDownEvt,
   input wire spmc_rx_t rxTlp,
   output spmc_hp_out_t hotplugOut,
   output logic link_up_out_n,
   output logic link_activity_out_n,
   output spmc_port_ctl_t portCtl,
   output spmc_rsp_t rxRsp,
   output logic portMerged,
   output logic portAttached,
   output logic partReset,
   output logic portResetEvt
);

   // Software-visible state, internal sequencing state and bus decode
   logic [1:0] partState_q;
   logic partStarted_q;
   logic partDone_q;
   logic partBusy_q;
   logic [7:0] settle_q;
   logic [1:0] portMode_q;
   logic [3:0] portPart_q;
   logic modeChanging_q;
   logic iscCtl_q;
   logic [31:0] gasAddr_q;
   logic [31:0] gasData_q;
   logic mergeCaught_q;
   logic strapTaken_q;
   logic [1:0] effMode;
   logic wbReq;
   logic wbWr;
   logic wbBusWr;
   logic wbRd;

   // Decode a byte-enable merge of a 32-bit register
   function automatic logic [31:0] merge32(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge32

   // Address match for a given register
   function automatic logic hit(input logic [31:0] adr,
                                input logic [7:0] reg_addr);
      return (adr[7:0] == reg_addr) && (adr[31:8] == 24'h000000);
   endfunction : hit

   // A held strobe is taken once; ack masks the second edge
   assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wbBusWr = wbReq && wb_we_i;
   assign wbWr = wbBusWr;
   assign wbRd = wbReq && !wb_we_i;

   // Effective mode: disabled partition forces attached port disabled
   always_comb begin
      effMode = portMode_q; // [R09]
      // Only the two attaching modes can be forced
      if (portMode_q[1] && (partState_q == SPMC_PART_DISABLED)) begin
         effMode = SPMC_MODE_DISABLED; // [R09]
      end
   end

   // Wishbone ack, one cycle after request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wbReq;
      end
   end

   // Wishbone read data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_dat_o <= 32'h00000000;
      end else if (wbRd) begin
         // Unmapped addresses read zero and are still acked
         wb_dat_o <= 32'h00000000;
         if (hit(wb_adr_i, PART_CTL_ADDR)) begin
            wb_dat_o[PART_STATE_LSB +: 2] <= partState_q;
         end else if (hit(wb_adr_i, PART_STS_ADDR)) begin
            wb_dat_o[STS_STARTED_BIT] <= partStarted_q;
            wb_dat_o[STS_DONE_BIT] <= partDone_q;
         end else if (hit(wb_adr_i, PORT_CTL_ADDR)) begin
            wb_dat_o[PORT_MODE_LSB +: 2] <= portMode_q;
            wb_dat_o[PORT_PART_LSB +: 4] <= portPart_q;
         end else if (hit(wb_adr_i, PORT_STS_ADDR)) begin
            wb_dat_o[1:0] <= effMode;
            wb_dat_o[2] <= mergeCaught_q;
            wb_dat_o[3] <= modeChanging_q;
         end else if (hit(wb_adr_i, PHY_CFG_ADDR)) begin
            wb_dat_o[PHY_ISC_BIT] <= iscCtl_q;
         end else if (hit(wb_adr_i, GAS_ADDR_ADDR)) begin
            wb_dat_o <= gasAddr_q;
         end else if (hit(wb_adr_i, GAS_DATA_ADDR)) begin
            wb_dat_o <= gasData_q;
         end
      end
   end

   // Partition state field and change sequencing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         partState_q <= PART_STATE_RST;
         partStarted_q <= 1'b0;
         partDone_q <= 1'b0;
         partBusy_q <= 1'b0;
         settle_q <= 8'h00;
      end else begin
         // Code 11 and a rewrite of the same state start nothing
         if (wbWr && hit(wb_adr_i, PART_CTL_ADDR) && wb_sel_i[0]
             && (wb_dat_i[PART_STATE_LSB +: 2] != 2'b11) // [R25]
             && (wb_dat_i[PART_STATE_LSB +: 2] != partState_q)) begin
            partState_q <= wb_dat_i[PART_STATE_LSB +: 2]; // [R02]
            partStarted_q <= 1'b1; // [R01]
            partDone_q <= 1'b0;
            partBusy_q <= 1'b1;
            settle_q <= 8'(SETTLE_CYC);
         end else if (partBusy_q) begin
            if (settle_q != 8'h00) begin
               settle_q <= settle_q - 8'h01; // [R04]
            // Done waits for a settling port and, for active, the reset pin
            end else if (!modeChanging_q
                         && !((partState_q == SPMC_PART_ACTIVE)
                              && !partition_reset_in_n)) begin
               partDone_q <= 1'b1; // [R01] [R04] [R07]
               partBusy_q <= 1'b0;
            end
         end
         // Write one to clear status; a set in progress wins
         if (wbWr && hit(wb_adr_i, PART_STS_ADDR) && wb_sel_i[0]) begin
            if (wb_dat_i[STS_STARTED_BIT] && !partBusy_q) begin
               partStarted_q <= 1'b0;
            end
            if (wb_dat_i[STS_DONE_BIT] && !partBusy_q) begin
               partDone_q <= 1'b0;
            end
         end
      end
   end

   // Port control field; any change starts a mode-change settle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         portMode_q <= PORT_MODE_RST;
         portPart_q <= PORT_PART_RST;
         modeChanging_q <= 1'b0;
      end else begin
         // Rewriting the same mode and partition is no mode change
         if (wbWr && hit(wb_adr_i, PORT_CTL_ADDR) && wb_sel_i[0]
             && ((wb_dat_i[PORT_MODE_LSB +: 2] != portMode_q)
                 || (wb_dat_i[PORT_PART_LSB +: 4] != portPart_q))) begin
            portMode_q <= wb_dat_i[PORT_MODE_LSB +: 2]; // [R08]
            portPart_q <= wb_dat_i[PORT_PART_LSB +: 4]; // [R08]
            modeChanging_q <= 1'b1;
         end else begin
            modeChanging_q <= 1'b0;
         end
      end
   end

   // Physical link configuration and global access registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         iscCtl_q <= 1'b0;
         gasAddr_q <= 32'h00000000;
         gasData_q <= 32'h00000000;
      end else begin
         if (wbWr && hit(wb_adr_i, PHY_CFG_ADDR) && wb_sel_i[0]) begin
            iscCtl_q <= wb_dat_i[PHY_ISC_BIT]; // [R24]
         end
         if (wbWr && hit(wb_adr_i, GAS_ADDR_ADDR)) begin
            gasAddr_q <= merge32(gasAddr_q, wb_dat_i, wb_sel_i); // [R20]
         end
         if (wbWr && hit(wb_adr_i, GAS_DATA_ADDR)) begin
            gasData_q <= merge32(gasData_q, wb_dat_i, wb_sel_i); // [R20]
         end
      end
   end

   // Merge strap caught once, right after switch reset release
   // Later strap levels never reach any port mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strapTaken_q <= 1'b0;
         mergeCaught_q <= 1'b0;
      end else if (!strapTaken_q) begin
         strapTaken_q <= 1'b1;
         mergeCaught_q <= !port_merge_strap_n; // [R15]
      end
   end

   // Pin outputs per effective mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hotplugOut <= '0;
         link_up_out_n <= 1'b1;
         link_activity_out_n <= 1'b1;
         portMerged <= 1'b0;
         portAttached <= 1'b0;
         partReset <= 1'b0;
      end else begin
         portMerged <= mergeCaught_q; // [R15]
         portAttached <= effMode[1]; // [R08]
         case (effMode)
            // Parked ports ignore hot-plug and partition inputs
            SPMC_MODE_DISABLED: begin
               hotplugOut <= '0; // [R10]
               link_up_out_n <= 1'b1; // [R10]
               link_activity_out_n <= 1'b1; // [R10]
               partReset <= 1'b0; // [R11]
            end
            SPMC_MODE_UNATTACHED: begin
               hotplugOut <= '0; // [R17]
               link_up_out_n <= !linkUpIn; // [R17]
               link_activity_out_n <= !linkActiveIn; // [R17]
               partReset <= 1'b0; // [R23]
            end
            SPMC_MODE_UPSTREAM: begin
               hotplugOut <= '0;
               link_up_out_n <= !linkUpIn;
               link_activity_out_n <= !linkActiveIn;
               partReset <= (partState_q == SPMC_PART_FRESET)
                            || !partition_reset_in_n;
            end
            default: begin
               hotplugOut.attnIndicator <= hotplugIn.attnButton;
               hotplugOut.interlock <= hotplugIn.latchSensor;
               hotplugOut.powerEnable <= hotplugIn.presence
                                         && !hotplugIn.powerFault;
               hotplugOut.powerIndicator <= hotplugIn.powerGood;
               hotplugOut.slotReset <= !hotplugIn.powerGood;
               link_up_out_n <= !linkUpIn;
               link_activity_out_n <= !linkActiveIn;
               partReset <= (partState_q == SPMC_PART_FRESET)
                            || !partition_reset_in_n;
            end
         endcase
      end
   end

   // Link and transaction layer controls per effective mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Out of reset the link sits in Detect with lanes off
         portCtl <= '0;
         portCtl.ltssmToDetect <= 1'b1;
      end else begin
         portCtl <= '0;
         case (effMode)
            SPMC_MODE_DISABLED: begin
               portCtl.ltssmToDetect <= 1'b1; // [R12]
               portCtl.downstreamLayout <= 1'b1; // [R14]
            end
            SPMC_MODE_UNATTACHED: begin
               portCtl.lanesOn <= 1'b1; // [R16]
               portCtl.clockRun <= 1'b1; // [R18]
               portCtl.ltssmUpstream <= 1'b1; // [R16]
               portCtl.holdL0 <= 1'b1; // [R16]
               portCtl.ignorePowerMgmt <= 1'b1; // [R16]
               portCtl.downstreamLayout <= 1'b1; // [R22]
               portCtl.autoSpeedChange <= iscCtl_q; // [R24]
            end
            SPMC_MODE_UPSTREAM: begin
               portCtl.lanesOn <= 1'b1;
               portCtl.clockRun <= 1'b1;
               portCtl.ltssmUpstream <= 1'b1;
               portCtl.msgEnable <= 1'b1;
               portCtl.autoSpeedChange <= iscCtl_q;
            end
            default: begin
               portCtl.lanesOn <= 1'b1;
               portCtl.clockRun <= 1'b1;
               portCtl.msgEnable <= 1'b1;
               portCtl.downstreamLayout <= 1'b1;
               portCtl.autoSpeedChange <= 1'b1;
            end
         endcase
      end
   end

   // Response to received TLPs and link events
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxRsp <= SPMC_RSP_NONE;
         portResetEvt <= 1'b0;
      end else begin
         rxRsp <= SPMC_RSP_NONE;
         portResetEvt <= 1'b0;
         case (effMode)
            // Even requests aimed at the port's own registers are refused
            SPMC_MODE_DISABLED: begin
               if (rxTlp.valid) begin
                  rxRsp <= SPMC_RSP_IGNORE; // [R11] [R13]
               end
            end
            SPMC_MODE_UNATTACHED: begin
               if (rxTlp.valid) begin
                  case (rxTlp.kind)
                     SPMC_TLP_CFG: rxRsp <= rxTlp.gasTarget ?
                        SPMC_RSP_NORMAL : SPMC_RSP_RETRY; // [R19] [R20]
                     SPMC_TLP_CPL: rxRsp <= SPMC_RSP_DROP_CREDIT; // [R21]
                     SPMC_TLP_MSG: rxRsp <= rxTlp.slotPowerMsg ?
                        SPMC_RSP_IGNORE : SPMC_RSP_UNSUPP; // [R23]
                     default: rxRsp <= SPMC_RSP_UNSUPP; // [R21]
                  endcase
               end
            end
            default: begin
               if (rxTlp.valid) begin
                  rxRsp <= SPMC_RSP_NORMAL;
               end
               portResetEvt <= linkDownEvt
                               || (rxTlp.valid && rxTlp.hotResetTs);
            end
         endcase
      end
   end
endmodule : switch_port_mode_control
`default_nettype wire

// ==== src/spmc_pkg.sv ====
package spmc_pkg;
   // Register byte addresses on the Wishbone slave
   localparam logic [7:0] PART_CTL_ADDR = 8'h00;
   localparam logic [7:0] PART_STS_ADDR = 8'h04;
   localparam logic [7:0] PORT_CTL_ADDR = 8'h08;
   localparam logic [7:0] PORT_STS_ADDR = 8'h0C;
   localparam logic [7:0] PHY_CFG_ADDR = 8'h10;
   localparam logic [7:0] GAS_ADDR_ADDR = 8'h14;
   localparam logic [7:0] GAS_DATA_ADDR = 8'h18;
   // Field positions
   localparam int PART_STATE_LSB = 0;
   localparam int STS_STARTED_BIT = 0;
   localparam int STS_DONE_BIT = 1;
   localparam int PORT_MODE_LSB = 0;
   localparam int PORT_PART_LSB = 4;
   localparam int PHY_ISC_BIT = 0;
   // Reset values
   localparam logic [1:0] PART_STATE_RST = 2'h0;
   localparam logic [1:0] PORT_MODE_RST = 2'h1;
   localparam logic [3:0] PORT_PART_RST = 4'h0;
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int SETTLE_NS = 50;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

   // Partition states
   typedef enum logic [1:0] {
      SPMC_PART_DISABLED = 2'b00,
      SPMC_PART_FRESET = 2'b01,
      SPMC_PART_ACTIVE = 2'b10
   } spmc_part_state_t;

   // Port modes
   typedef enum logic [1:0] {
      SPMC_MODE_DISABLED = 2'b00,
      SPMC_MODE_UNATTACHED = 2'b01,
      SPMC_MODE_UPSTREAM = 2'b10,
      SPMC_MODE_DOWNSTREAM = 2'b11
   } spmc_port_mode_t;

   // Received TLP kinds from the port's link logic
   typedef enum logic [1:0] {
      SPMC_TLP_CFG = 2'b00,
      SPMC_TLP_REQ = 2'b01,
      SPMC_TLP_CPL = 2'b10,
      SPMC_TLP_MSG = 2'b11
   } spmc_tlp_kind_t;

   // Responses to received TLPs
   typedef enum logic [2:0] {
      SPMC_RSP_NONE = 3'b000,
      SPMC_RSP_NORMAL = 3'b001,
      SPMC_RSP_RETRY = 3'b010,
      SPMC_RSP_UNSUPP = 3'b011,
      SPMC_RSP_DROP_CREDIT = 3'b100,
      SPMC_RSP_IGNORE = 3'b101
   } spmc_rsp_t;

   // Received TLP descriptor
   typedef struct packed {
      logic valid;
      spmc_tlp_kind_t kind;
      logic gasTarget;
      logic hotResetTs;
      logic slotPowerMsg;
   } spmc_rx_t;

   // Hot-plug input group, active high levels
   typedef struct packed {
      logic attnButton;
      logic latchSensor;
      logic presence;
      logic powerFault;
      logic powerGood;
   } spmc_hp_in_t;

   // Hot-plug output group, asserted levels high
   typedef struct packed {
      logic attnIndicator;
      logic interlock;
      logic powerEnable;
      logic powerIndicator;
      logic slotReset;
   } spmc_hp_out_t;

   // Port behaviour controls sent to link and transaction logic
   typedef struct packed {
      logic lanesOn;
      logic clockRun;
      logic ltssmToDetect;
      logic ltssmUpstream;
      logic holdL0;
      logic ignorePowerMgmt;
      logic msgEnable;
      logic downstreamLayout;
      logic autoSpeedChange;
   } spmc_port_ctl_t;
endpackage : spmc_pkg

// ==== tb/spmc_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module spmc_monitor
   import spmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic linkUpIn,
   input wire spmc_rx_t rxTlp,
   input wire spmc_hp_out_t hotplugOut,
   input wire logic link_up_out_n,
   input wire logic link_activity_out_n,
   input wire spmc_port_ctl_t portCtl,
   input wire spmc_rsp_t rxRsp,
   input wire logic portAttached,
   input wire logic portResetEvt
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic unatt;
   logic runQ;
   // Lanes live but no partition means unattached
   assign unatt = portCtl.lanesOn && !portAttached;
   // Masks the reset values seen at the first edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) runQ <= 1'b0;
      else runQ <= 1'b1;
   end
   // Bus handshake
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   a_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("no ack");
   // Disabled port
   a_dis_quiet: assert property (!portCtl.lanesOn |->
      hotplugOut == '0 && link_up_out_n && link_activity_out_n
      && !portCtl.msgEnable && !portResetEvt) else $error("dis out");
   a_dis_detect: assert property (!portCtl.lanesOn |->
      portCtl.ltssmToDetect && !portCtl.clockRun) else $error("dis ltssm");
   a_dis_layout: assert property (runQ && !portCtl.lanesOn |->
      portCtl.downstreamLayout) else $error("dis layout");
   a_dis_ignore: assert property (!portCtl.lanesOn && rxTlp.valid
      |=> rxRsp == SPMC_RSP_IGNORE) else $error("dis answered");
   // Unattached port
   a_unatt_quiet: assert property (unatt |-> hotplugOut == '0
      && !portCtl.msgEnable && !portResetEvt) else $error("unatt out");
   a_unatt_link: assert property (unatt |-> portCtl.ltssmUpstream
      && portCtl.holdL0 && portCtl.ignorePowerMgmt
      && portCtl.downstreamLayout) else $error("unatt ctl");
   a_link_live: assert property (unatt && $past(unatt) |->
      link_up_out_n == !$past(linkUpIn)) else $error("link dead");
   a_cfg_retry: assert property (unatt && rxTlp.valid
      && rxTlp.kind == SPMC_TLP_CFG && !rxTlp.gasTarget
      |=> rxRsp == SPMC_RSP_RETRY) else $error("no retry");
   a_gas_normal: assert property (unatt && rxTlp.valid
      && rxTlp.kind == SPMC_TLP_CFG && rxTlp.gasTarget
      |=> rxRsp == SPMC_RSP_NORMAL) else $error("gas refused");
   a_req_unsupp: assert property (unatt && rxTlp.valid
      && rxTlp.kind inside {SPMC_TLP_REQ, SPMC_TLP_CPL}
      |=> rxRsp == ($past(rxTlp.kind) == SPMC_TLP_REQ ? SPMC_RSP_UNSUPP
      : SPMC_RSP_DROP_CREDIT)) else $error("bad rsp");
   c_retry: cover property (rxRsp == SPMC_RSP_RETRY);
   c_attach: cover property (portAttached);
   c_revive: cover property (!portCtl.lanesOn ##1 portCtl.lanesOn);
endmodule : spmc_monitor
bind switch_port_mode_control spmc_monitor mon_u (.clk(clk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .linkUpIn(linkUpIn), .rxTlp(rxTlp), .hotplugOut(hotplugOut),
   .link_up_out_n(link_up_out_n), .link_activity_out_n(link_activity_out_n),
   .portCtl(portCtl), .rxRsp(rxRsp), .portAttached(portAttached),
   .portResetEvt(portResetEvt));
`default_nettype wire

// ==== tb/spmc_link_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module spmc_link_partner
   import spmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic goSend,
   input wire spmc_tlp_kind_t goKind,
   input wire logic goGas,
   output spmc_rx_t rxTlp,
   output logic linkUp,
   output logic linkActive,
   output logic linkDown
);
   // One descriptor per command; idle fields keep toggling
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxTlp <= '0;
      end else if (goSend) begin
         rxTlp.valid <= 1'b1;
         rxTlp.kind <= goKind;
         rxTlp.gasTarget <= goGas;
         rxTlp.hotResetTs <= 1'($urandom);
         rxTlp.slotPowerMsg <= 1'($urandom);
      end else begin
         rxTlp <= {1'b0, ~rxTlp[4:0]};
      end
   end
   // Link status wanders, with occasional link-down events
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         linkUp <= 1'b0;
         linkActive <= 1'b0;
         linkDown <= 1'b0;
      end else begin
         linkUp <= ($urandom % 8) != 0;
         linkActive <= 1'($urandom);
         linkDown <= ($urandom % 16) == 0;
      end
   end
endmodule : spmc_link_partner
`default_nettype wire

// ==== tb/switch_port_mode_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module switch_port_mode_control_test
   import spmc_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] adr, wdat, rdat, q;
   logic [3:0] sel;
   logic we, cyc, stb, ack, pRstN, strapN, go, gas, upN, actN;
   logic merged, att, pRst, rEvt, lUp, lAct, lDown;
   spmc_hp_in_t hpIn;
   spmc_hp_out_t hpOut;
   spmc_tlp_kind_t kind;
   spmc_rx_t rx;
   spmc_port_ctl_t ctl;
   spmc_rsp_t rsp;
   logic [1:0] partSt;
   logic dis = 1'b0;
   int err_count = 0;
   int num_checks = 0;
   int cycN = 0;

   switch_port_mode_control dut_u (.clk(clk), .rst(rst), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
      .partition_reset_in_n(pRstN), .port_merge_strap_n(strapN),
      .hotplugIn(hpIn), .linkUpIn(lUp), .linkActiveIn(lAct),
      .linkDownEvt(lDown), .rxTlp(rx), .hotplugOut(hpOut),
      .link_up_out_n(upN), .link_activity_out_n(actN), .portCtl(ctl),
      .rxRsp(rsp), .portMerged(merged), .portAttached(att),
      .partReset(pRst), .portResetEvt(rEvt));
   spmc_link_partner partner_u (.clk(clk), .rst(rst), .goSend(go),
      .goKind(kind), .goGas(gas), .rxTlp(rx), .linkUp(lUp),
      .linkActive(lAct), .linkDown(lDown));

   always #5 clk = ~clk;
   // Random hot-plug levels; a parked port must not react
   always @(posedge clk) hpIn <= 5'($urandom);
   // Hang guard
   always @(posedge clk) begin
      cycN++;
      if (cycN == 20000) begin
         err_count++;
         print_verdict();
      end
   end

   task automatic print_verdict;
      if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // Classic single Wishbone cycle; only the hang guard ends a wait
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {24'h000000, a};
      wdat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   // Polls for change-done, then clears both flags
   task automatic wait_done(input logic [1:0] st);
      int n;
      n = 0;
      do begin
         wb(1'b0, PART_STS_ADDR, 32'h0);
         n++;
      end while (q[1] !== 1'b1 && n < 100);
      chk(q[1:0], 2'h3);
      wb(1'b1, PART_STS_ADDR, 32'h3);
      wb(1'b0, PART_STS_ADDR, 32'h0);
      chk(q[1:0], 2'h0);
      partSt = st;
   endtask : wait_done

   task automatic set_part(input logic [1:0] st);
      wb(1'b1, PART_CTL_ADDR, {30'h0, st});
      wait_done(st);
   endtask : set_part

   function automatic logic [1:0] eff_mode(input logic [1:0] m);
      return (m[1] && partSt == SPMC_PART_DISABLED) ? 2'h0 : m;
   endfunction : eff_mode

   task automatic set_mode(input logic [1:0] m);
      int n;
      n = 0;
      wb(1'b1, PORT_CTL_ADDR, {30'h0, m});
      do begin
         wb(1'b0, PORT_STS_ADDR, 32'h0);
         n++;
      end while (q[3] !== 1'b0 && n < 50);
      chk(q[1:0], eff_mode(m));
      chk(att, eff_mode(m) >= 2'h2);
   endtask : set_mode

   function automatic spmc_rsp_t exp_rsp(input spmc_tlp_kind_t k,
      input logic g, input logic sp);
      if (dis) return SPMC_RSP_IGNORE;
      if (k == SPMC_TLP_CFG) return g ? SPMC_RSP_NORMAL : SPMC_RSP_RETRY;
      if (k == SPMC_TLP_REQ) return SPMC_RSP_UNSUPP;
      if (k == SPMC_TLP_MSG) return sp ? SPMC_RSP_IGNORE : SPMC_RSP_UNSUPP;
      return SPMC_RSP_DROP_CREDIT;
   endfunction : exp_rsp

   // Partner sends one descriptor; response is sampled two edges on
   task automatic rx_chk(input spmc_tlp_kind_t k, input logic g);
      logic sp;
      @(posedge clk);
      go <= 1'b1;
      kind <= k;
      gas <= g;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      sp = rx.slotPowerMsg;
      @(posedge clk);
      chk(rsp, exp_rsp(k, g, sp));
   endtask : rx_chk

   initial begin
      int i;
      i = $urandom(32'h7C8B);
      {adr, wdat, sel, we, cyc, stb, go, gas} = '0;
      kind = SPMC_TLP_CFG;
      pRstN = 1'b1;
      strapN = 1'b0;
      partSt = SPMC_PART_DISABLED;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      strapN <= 1'b1;
      wb(1'b0, PORT_STS_ADDR, 32'h0);
      chk(q[3:0], 4'h5);
      wb(1'b1, 8'h40, 32'hFFFFFFFF);
      wb(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      chk(ctl.autoSpeedChange, 1'b0);
      wb(1'b1, PHY_CFG_ADDR, 32'h1);
      wb(1'b0, PHY_CFG_ADDR, 32'h0);
      chk(q, 32'h1);
      chk(ctl.autoSpeedChange, 1'b1);
      rx_chk(SPMC_TLP_CFG, 1'b1);
      for (i = 0; i < 40; i++) begin
         rx_chk(spmc_tlp_kind_t'(i % 4), 1'($urandom));
      end
      // Reset input low holds off the move to active
      pRstN <= 1'b0;
      wb(1'b1, PART_CTL_ADDR, {30'h0, SPMC_PART_ACTIVE});
      repeat (30) @(posedge clk);
      wb(1'b0, PART_STS_ADDR, 32'h0);
      chk(q[1:0], 2'h1);
      pRstN <= 1'b1;
      wait_done(SPMC_PART_ACTIVE);
      set_part(SPMC_PART_FRESET);
      set_part(SPMC_PART_ACTIVE);
      wb(1'b1, PART_CTL_ADDR, 32'h3);
      wb(1'b0, PART_STS_ADDR, 32'h0);
      chk(q[1:0], 2'h0);
      set_mode(SPMC_MODE_UPSTREAM);
      set_mode(SPMC_MODE_DOWNSTREAM);
      set_part(SPMC_PART_DISABLED);
      wb(1'b0, PORT_STS_ADDR, 32'h0);
      chk(q[3:0], 4'h4);
      pRstN <= 1'b0;
      repeat (10) @(posedge clk);
      chk({hpOut, upN, actN, ctl.lanesOn, rEvt, pRst}, 10'h018);
      dis = 1'b1;
      rx_chk(SPMC_TLP_CFG, 1'b0);
      dis = 1'b0;
      pRstN <= 1'b1;
      set_mode(SPMC_MODE_UPSTREAM);
      set_mode(SPMC_MODE_DISABLED);
      set_part(SPMC_PART_ACTIVE);
      set_mode(SPMC_MODE_UNATTACHED);
      rx_chk(SPMC_TLP_CFG, 1'b0);
      chk(merged, 1'b1);
      print_verdict();
   end
endmodule : switch_port_mode_control_test
`default_nettype wire
